// ===== emcs_pkg.sv
// emcs_pkg: constants and carrier types for the event mask, clear and source-select block
// assumes a byte-wide host register port and one 125 MHz system clock
package emcs_pkg;

	// ------------------------------------------------------------
	// register offsets
	// ------------------------------------------------------------
	localparam logic [15:0] EMCS_OFS_COMMON_FLAGS = 16'h2100;
	localparam logic [15:0] EMCS_OFS_SOCKET_SUMMARY = 16'h2101;
	localparam logic [15:0] EMCS_OFS_SOCKETLESS_FLAGS = 16'h2102;
	localparam logic [15:0] EMCS_OFS_COMMON_EVENT_MASK = 16'h2104;
	localparam logic [15:0] EMCS_OFS_COMMON_FLAG_CLEAR = 16'h2108;
	localparam logic [15:0] EMCS_OFS_SOCKET_EVENT_MASK = 16'h2114;
	localparam logic [15:0] EMCS_OFS_SOCKETLESS_EVENT_MASK = 16'h2124;
	localparam logic [15:0] EMCS_OFS_SOCKETLESS_FLAG_CLEAR = 16'h2128;
	localparam logic [15:0] EMCS_OFS_SOCKETLESS_SOURCE_SELECT = 16'h212c;

	// ------------------------------------------------------------
	// widths and reset values
	// ------------------------------------------------------------
	localparam int EMCS_DW = 8;
	localparam int EMCS_SOCKETS = 8;
	localparam logic [7:0] EMCS_RST_BYTE = 8'h00;
	localparam logic [7:0] EMCS_ZERO_BYTE = 8'h00;

	// ------------------------------------------------------------
	// common event bit positions (6:5 and 3 reserved)
	// ------------------------------------------------------------
	localparam int EMCS_BIT_MAGIC_PACKET_WAKE = 7;
	localparam int EMCS_BIT_IPV6_PORT_UNREACHABLE = 4;
	localparam int EMCS_BIT_IPV4_ADDRESS_CONFLICT = 2;
	localparam int EMCS_BIT_IPV4_PORT_UNREACHABLE = 1;
	localparam int EMCS_BIT_PPPOE_SESSION_ENDED = 0;
	localparam logic [7:0] EMCS_COMMON_VALID = 8'h97;

	// ------------------------------------------------------------
	// socket-less event bit positions
	// ------------------------------------------------------------
	localparam int EMCS_BIT_COMMAND_TIMEOUT = 7;
	localparam int EMCS_BIT_IPV4_ADDRESS_RESOLVE = 6;
	localparam int EMCS_BIT_IPV4_ECHO_REPLY = 5;
	localparam int EMCS_BIT_IPV6_NEIGHBOR_RESOLVE = 4;
	localparam int EMCS_BIT_IPV6_ECHO_REPLY = 3;
	localparam int EMCS_BIT_DUPLICATE_ADDRESS_PROBE = 2;
	localparam int EMCS_BIT_ROUTER_SOLICIT_DONE = 1;
	localparam int EMCS_BIT_ROUTER_ADVERT_RECEIVED = 0;
	localparam logic [7:0] EMCS_SOCKETLESS_VALID = 8'hff;

	// ------------------------------------------------------------
	// source-select codes and address kinds
	// ------------------------------------------------------------
	localparam logic [7:0] EMCS_SEL_AUTO = 8'h00;
	localparam logic [7:0] EMCS_SEL_LINK_LOCAL = 8'h02;
	localparam logic [7:0] EMCS_SEL_GLOBAL = 8'h03;
	localparam logic [9:0] EMCS_LINK_LOCAL_PREFIX = 10'h3fa;
	localparam int EMCS_LINK_LOCAL_PLEN = 10;
	localparam logic [2:0] EMCS_GLOBAL_UNICAST_PREFIX = 3'h1;
	localparam int EMCS_GLOBAL_UNICAST_PLEN = 3;

	// ------------------------------------------------------------
	// carrier types
	// ------------------------------------------------------------
	typedef struct packed {
		logic wr;
		logic rd;
		logic [15:0] addr;
		logic [7:0] wdata;
	} emcs_reg_req_t;

	typedef struct packed {
		logic [127:0] dest;
		logic [127:0] link_local;
		logic [127:0] global_addr;
	} emcs_ipv6_set_t;

	typedef enum logic [1:0] {
		EMCS_KIND_LINK_LOCAL,
		EMCS_KIND_GLOBAL_UNICAST,
		EMCS_KIND_OTHER
	} emcs_kind_t;

endpackage

// ===== emcs_flag_bank.sv
// emcs_flag_bank: sticky event flags with write-one-to-clear and mask gating
// assumes set pulses and clear strobes are synchronous to clk_sys_i
`timescale 1ns/1ps
`default_nettype none
module emcs_flag_bank #(
	parameter int W = 8,
	parameter logic [W-1:0] VALID = '1
) (
	// clock, reset, enable
	input wire logic clk_sys_i,
	input wire logic srst_i,
	input wire logic ce_i,
	// events and clear
	input wire logic [W-1:0] set_i,
	input wire logic clr_wr_i,
	input wire logic [W-1:0] clr_data_i,
	// mask and result
	input wire logic [W-1:0] mask_i,
	output logic [W-1:0] flags_o,
	output logic pend_o
);
	logic [W-1:0] flags_r;
	logic [W-1:0] clr_bits;

	// zero bits of a clear write leave flags alone
	assign clr_bits = clr_wr_i ? clr_data_i : '0;

	// ------------------------------------------------------------
	// flags: a set in the clearing cycle survives
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			flags_r <= '0;
		end else if (ce_i) begin
			flags_r <= ((flags_r & ~clr_bits) | set_i) & VALID;
		end
	end

	assign flags_o = flags_r;
	assign pend_o = |(flags_r & mask_i);
endmodule // emcs_flag_bank
`default_nettype wire

// ===== emcs_src_sel.sv
// emcs_src_sel: picks the source ipv6 address for socket-less commands
// assumes address inputs are stable while a command is prepared
`timescale 1ns/1ps
`default_nettype none
module emcs_src_sel
	import emcs_pkg::*;
(
	// clock, reset, enable
	input wire logic clk_sys_i,
	input wire logic srst_i,
	input wire logic ce_i,
	// selection
	input wire logic [7:0] select_i,
	input wire emcs_pkg::emcs_ipv6_set_t addrs_i,
	output logic [127:0] chosen_source_ipv6_o
);
	emcs_kind_t dest_kind;
	logic [127:0] chosen_nxt;
	logic [127:0] chosen_r;

	// ------------------------------------------------------------
	// destination kind
	// ------------------------------------------------------------
	always_comb begin
		if (addrs_i.dest[127 -: EMCS_LINK_LOCAL_PLEN] == EMCS_LINK_LOCAL_PREFIX) begin
			dest_kind = EMCS_KIND_LINK_LOCAL;
		end else if (addrs_i.dest[127 -: EMCS_GLOBAL_UNICAST_PLEN] == EMCS_GLOBAL_UNICAST_PREFIX) begin
			dest_kind = EMCS_KIND_GLOBAL_UNICAST;
		end else begin
			dest_kind = EMCS_KIND_OTHER;
		end
	end

	// ------------------------------------------------------------
	// choice; undefined codes behave as automatic
	// ------------------------------------------------------------
	always_comb begin
		case (select_i)
			EMCS_SEL_LINK_LOCAL: begin
				chosen_nxt = addrs_i.link_local;
			end
			EMCS_SEL_GLOBAL: begin
				chosen_nxt = addrs_i.global_addr;
			end
			default: begin
				// other destinations take the global address, routable scope
				if (dest_kind == EMCS_KIND_LINK_LOCAL) begin
					chosen_nxt = addrs_i.link_local;
				end else begin
					chosen_nxt = addrs_i.global_addr;
				end
			end
		endcase
	end

	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			chosen_r <= '0;
		end else if (ce_i) begin
			chosen_r <= chosen_nxt;
		end
	end

	assign chosen_source_ipv6_o = chosen_r;
endmodule // emcs_src_sel
`default_nettype wire

// ===== emcs_event_ctrl.sv
// emcs_event_ctrl: interrupt masks, flag clearing and socket-less source select
// assumes a synchronous byte-wide host register port and pulse event sources
`timescale 1ns/1ps
`default_nettype none
module emcs_event_ctrl
	import emcs_pkg::*;
(
	// clock, reset, enable
	input wire logic clk_sys_i,
	input wire logic srst_i,
	input wire logic ce_i,
	// host register port
	input wire emcs_pkg::emcs_reg_req_t reg_req_i,
	output logic [7:0] reg_rdata_o,
	// event sources
	input wire logic [7:0] common_event_set_i,
	input wire logic [7:0] socketless_event_set_i,
	input wire logic [63:0] per_socket_flags_i,
	// interrupt
	input wire logic global_interrupt_enable_i,
	output logic interrupt_pin_low_n_o,
	// source address selection
	input wire emcs_pkg::emcs_ipv6_set_t ipv6_addrs_i,
	output logic [7:0] socketless_source_select_o,
	output logic [127:0] chosen_source_ipv6_o
);
	// ------------------------------------------------------------
	// declarations
	// ------------------------------------------------------------
	logic [7:0] common_event_mask_r;
	logic [7:0] socket_event_mask_r;
	logic [7:0] socketless_event_mask_r;
	logic [7:0] socketless_source_select_r;
	logic [7:0] reg_rdata_r;
	logic [7:0] reg_rdata_nxt;
	logic interrupt_pin_low_n_r;
	logic interrupt_pin_low_n_nxt;
	logic [7:0] common_event_flags;
	logic [7:0] socketless_event_flags;
	logic [7:0] socket_summary_flags;
	logic common_pend;
	logic socketless_pend;
	logic socket_pend;
	logic any_pend;
	logic wr_common_mask;
	logic wr_common_clear;
	logic wr_socket_mask;
	logic wr_socketless_mask;
	logic wr_socketless_clear;
	logic wr_source_select;
	logic [7:0] common_set;
	logic [7:0] socketless_set;

	// ------------------------------------------------------------
	// write decode
	// ------------------------------------------------------------
	// one strobe per offset; writes to read-only or unmapped offsets fall through
	always_comb begin
		wr_common_mask = 1'b0;
		wr_common_clear = 1'b0;
		wr_socket_mask = 1'b0;
		wr_socketless_mask = 1'b0;
		wr_socketless_clear = 1'b0;
		wr_source_select = 1'b0;
		if (reg_req_i.wr) begin
			case (reg_req_i.addr)
				EMCS_OFS_COMMON_EVENT_MASK: begin
					wr_common_mask = 1'b1;
				end
				EMCS_OFS_COMMON_FLAG_CLEAR: begin
					wr_common_clear = 1'b1;
				end
				EMCS_OFS_SOCKET_EVENT_MASK: begin
					wr_socket_mask = 1'b1;
				end
				EMCS_OFS_SOCKETLESS_EVENT_MASK: begin
					wr_socketless_mask = 1'b1;
				end
				EMCS_OFS_SOCKETLESS_FLAG_CLEAR: begin
					wr_socketless_clear = 1'b1;
				end
				EMCS_OFS_SOCKETLESS_SOURCE_SELECT: begin
					wr_source_select = 1'b1;
				end
				default: begin
					wr_common_mask = 1'b0;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// common event mask
	// ------------------------------------------------------------
	// reserved bits are never stored, so they read back as zero
	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			common_event_mask_r <= EMCS_RST_BYTE;
		end else if (ce_i && wr_common_mask) begin
			common_event_mask_r <= reg_req_i.wdata & EMCS_COMMON_VALID;
		end
	end

	// ------------------------------------------------------------
	// socket event mask
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			socket_event_mask_r <= EMCS_RST_BYTE;
		end else if (ce_i && wr_socket_mask) begin
			socket_event_mask_r <= reg_req_i.wdata;
		end
	end

	// ------------------------------------------------------------
	// socket-less event mask
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			socketless_event_mask_r <= EMCS_RST_BYTE;
		end else if (ce_i && wr_socketless_mask) begin
			socketless_event_mask_r <= reg_req_i.wdata & EMCS_SOCKETLESS_VALID;
		end
	end

	// ------------------------------------------------------------
	// source select
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			socketless_source_select_r <= EMCS_RST_BYTE;
		end else if (ce_i && wr_source_select) begin
			socketless_source_select_r <= reg_req_i.wdata;
		end
	end

	assign socketless_source_select_o = socketless_source_select_r;

	// ------------------------------------------------------------
	// event routing into flag positions
	// ------------------------------------------------------------
	always_comb begin
		common_set = EMCS_ZERO_BYTE;
		common_set[EMCS_BIT_MAGIC_PACKET_WAKE] = common_event_set_i[EMCS_BIT_MAGIC_PACKET_WAKE];
		common_set[EMCS_BIT_IPV6_PORT_UNREACHABLE] = common_event_set_i[EMCS_BIT_IPV6_PORT_UNREACHABLE];
		common_set[EMCS_BIT_IPV4_ADDRESS_CONFLICT] = common_event_set_i[EMCS_BIT_IPV4_ADDRESS_CONFLICT];
		common_set[EMCS_BIT_IPV4_PORT_UNREACHABLE] = common_event_set_i[EMCS_BIT_IPV4_PORT_UNREACHABLE];
		common_set[EMCS_BIT_PPPOE_SESSION_ENDED] = common_event_set_i[EMCS_BIT_PPPOE_SESSION_ENDED];
	end

	// one line a bit keeps each flag tied to its own mask position
	always_comb begin
		socketless_set = EMCS_ZERO_BYTE;
		socketless_set[EMCS_BIT_COMMAND_TIMEOUT] = socketless_event_set_i[EMCS_BIT_COMMAND_TIMEOUT];
		socketless_set[EMCS_BIT_IPV4_ADDRESS_RESOLVE] = socketless_event_set_i[EMCS_BIT_IPV4_ADDRESS_RESOLVE];
		socketless_set[EMCS_BIT_IPV4_ECHO_REPLY] = socketless_event_set_i[EMCS_BIT_IPV4_ECHO_REPLY];
		socketless_set[EMCS_BIT_IPV6_NEIGHBOR_RESOLVE] = socketless_event_set_i[EMCS_BIT_IPV6_NEIGHBOR_RESOLVE];
		socketless_set[EMCS_BIT_IPV6_ECHO_REPLY] = socketless_event_set_i[EMCS_BIT_IPV6_ECHO_REPLY];
		socketless_set[EMCS_BIT_DUPLICATE_ADDRESS_PROBE] = socketless_event_set_i[EMCS_BIT_DUPLICATE_ADDRESS_PROBE];
		socketless_set[EMCS_BIT_ROUTER_SOLICIT_DONE] = socketless_event_set_i[EMCS_BIT_ROUTER_SOLICIT_DONE];
		socketless_set[EMCS_BIT_ROUTER_ADVERT_RECEIVED] = socketless_event_set_i[EMCS_BIT_ROUTER_ADVERT_RECEIVED];
	end

	// ------------------------------------------------------------
	// common flags
	// ------------------------------------------------------------
	emcs_flag_bank #(
		.W(EMCS_DW),
		.VALID(EMCS_COMMON_VALID)
	) u_common_flags (
		.clk_sys_i(clk_sys_i),
		.srst_i(srst_i),
		.ce_i(ce_i),
		.set_i(common_set),
		.clr_wr_i(wr_common_clear),
		.clr_data_i(reg_req_i.wdata),
		.mask_i(common_event_mask_r),
		.flags_o(common_event_flags),
		.pend_o(common_pend)
	);

	// ------------------------------------------------------------
	// socket-less flags
	// ------------------------------------------------------------
	emcs_flag_bank #(
		.W(EMCS_DW),
		.VALID(EMCS_SOCKETLESS_VALID)
	) u_socketless_flags (
		.clk_sys_i(clk_sys_i),
		.srst_i(srst_i),
		.ce_i(ce_i),
		.set_i(socketless_set),
		.clr_wr_i(wr_socketless_clear),
		.clr_data_i(reg_req_i.wdata),
		.mask_i(socketless_event_mask_r),
		.flags_o(socketless_event_flags),
		.pend_o(socketless_pend)
	);

	// ------------------------------------------------------------
	// socket summary
	// ------------------------------------------------------------
	// live view: clears by itself once software clears the socket's flags
	always_comb begin
		socket_summary_flags = EMCS_ZERO_BYTE;
		for (int n = 0; n < EMCS_SOCKETS; n++) begin
			socket_summary_flags[n] = |per_socket_flags_i[n*EMCS_DW +: EMCS_DW];
		end
	end

	assign socket_pend = |(socket_summary_flags & socket_event_mask_r);

	// ------------------------------------------------------------
	// interrupt pin
	// ------------------------------------------------------------
	assign any_pend = common_pend | socketless_pend | socket_pend;
	assign interrupt_pin_low_n_nxt = ~(global_interrupt_enable_i & any_pend);

	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			interrupt_pin_low_n_r <= 1'b1;
		end else if (ce_i) begin
			interrupt_pin_low_n_r <= interrupt_pin_low_n_nxt;
		end
	end

	assign interrupt_pin_low_n_o = interrupt_pin_low_n_r;

	// ------------------------------------------------------------
	// read path
	// ------------------------------------------------------------
	// clear registers and unmapped addresses answer zero
	always_comb begin
		case (reg_req_i.addr)
			EMCS_OFS_COMMON_FLAGS: begin
				reg_rdata_nxt = common_event_flags;
			end
			EMCS_OFS_SOCKET_SUMMARY: begin
				reg_rdata_nxt = socket_summary_flags;
			end
			EMCS_OFS_SOCKETLESS_FLAGS: begin
				reg_rdata_nxt = socketless_event_flags;
			end
			EMCS_OFS_COMMON_EVENT_MASK: begin
				reg_rdata_nxt = common_event_mask_r;
			end
			EMCS_OFS_SOCKET_EVENT_MASK: begin
				reg_rdata_nxt = socket_event_mask_r;
			end
			EMCS_OFS_SOCKETLESS_EVENT_MASK: begin
				reg_rdata_nxt = socketless_event_mask_r;
			end
			EMCS_OFS_SOCKETLESS_SOURCE_SELECT: begin
				reg_rdata_nxt = socketless_source_select_r;
			end
			default: begin
				reg_rdata_nxt = EMCS_ZERO_BYTE;
			end
		endcase
	end

	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			reg_rdata_r <= EMCS_RST_BYTE;
		end else if (ce_i && reg_req_i.rd) begin
			reg_rdata_r <= reg_rdata_nxt;
		end
	end

	assign reg_rdata_o = reg_rdata_r;

	// ------------------------------------------------------------
	// source address selector
	// ------------------------------------------------------------
	emcs_src_sel u_src_sel (
		.clk_sys_i(clk_sys_i),
		.srst_i(srst_i),
		.ce_i(ce_i),
		.select_i(socketless_source_select_r),
		.addrs_i(ipv6_addrs_i),
		.chosen_source_ipv6_o(chosen_source_ipv6_o)
	);
endmodule // emcs_event_ctrl
`default_nettype wire

// ===== emcs_event_ctrl_asserts.sv
// emcs_event_ctrl_asserts: port checks for the event controller
// assumes bind onto emcs_event_ctrl; masks shadowed from host writes
`timescale 1ns/1ps
`default_nettype none
module emcs_event_ctrl_asserts
	import emcs_pkg::*;
(
	// clock and control
	input wire logic clk_sys_i,
	input wire logic srst_i,
	input wire logic ce_i,
	// host port
	input wire emcs_pkg::emcs_reg_req_t reg_req_i,
	input wire logic [7:0] reg_rdata_o,
	// interrupt
	input wire logic [63:0] per_socket_flags_i,
	input wire logic global_interrupt_enable_i,
	input wire logic interrupt_pin_low_n_o,
	// source select
	input wire emcs_pkg::emcs_ipv6_set_t ipv6_addrs_i,
	input wire logic [7:0] socketless_source_select_o,
	input wire logic [127:0] chosen_source_ipv6_o
);
	// ------------------------------------------------------------
	// shadow masks
	// ------------------------------------------------------------
	logic [7:0] cmask_r;
	logic [7:0] smask_r;
	logic [7:0] summ;
	always_ff @(posedge clk_sys_i) begin
		if (srst_i)
			cmask_r <= 8'h00;
		else if (ce_i && reg_req_i.wr && reg_req_i.addr == EMCS_OFS_COMMON_EVENT_MASK)
			cmask_r <= reg_req_i.wdata;
	end
	always_ff @(posedge clk_sys_i) begin
		if (srst_i)
			smask_r <= 8'h00;
		else if (ce_i && reg_req_i.wr && reg_req_i.addr == EMCS_OFS_SOCKET_EVENT_MASK)
			smask_r <= reg_req_i.wdata;
	end
	always_comb begin
		for (int n = 0; n < 8; n++) summ[n] = |per_socket_flags_i[8*n +: 8];
	end
	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (srst_i);
	chk_reset_idle_state:
		assert property ($fell(srst_i) |-> interrupt_pin_low_n_o && socketless_source_select_o == 8'h00)
		else $error("not idle after reset");
	chk_mask_readback:
		assert property (ce_i && reg_req_i.rd && !reg_req_i.wr && reg_req_i.addr == EMCS_OFS_COMMON_EVENT_MASK
			|=> reg_rdata_o == ($past(cmask_r) & 8'h97)) else $error("common mask read wrong");
	chk_clear_reads_zero:
		assert property (ce_i && reg_req_i.rd && (reg_req_i.addr == 16'h2108 || reg_req_i.addr == 16'h2128)
			|=> reg_rdata_o == 8'h00) else $error("clear register read nonzero");
	chk_enable_gates_pin:
		assert property (ce_i && !global_interrupt_enable_i |=> interrupt_pin_low_n_o) else $error("pin low while disabled");
	chk_summary_raises_irq:
		assert property (ce_i && global_interrupt_enable_i && |(summ & smask_r) |=> !interrupt_pin_low_n_o)
		else $error("socket summary did not raise pin");
	chk_fixed_link_local:
		assert property (ce_i && socketless_source_select_o == 8'h02
			|=> chosen_source_ipv6_o == $past(ipv6_addrs_i.link_local)) else $error("fixed link-local wrong");
	chk_fixed_global:
		assert property (ce_i && socketless_source_select_o == 8'h03
			|=> chosen_source_ipv6_o == $past(ipv6_addrs_i.global_addr)) else $error("fixed global wrong");
	chk_auto_link_local:
		assert property (ce_i && socketless_source_select_o == 8'h00 && ipv6_addrs_i.dest[127:118] == 10'h3fa
			|=> chosen_source_ipv6_o == $past(ipv6_addrs_i.link_local)) else $error("auto link-local wrong");
	chk_auto_global:
		assert property (ce_i && socketless_source_select_o == 8'h00 && ipv6_addrs_i.dest[127:125] == 3'h1
			|=> chosen_source_ipv6_o == $past(ipv6_addrs_i.global_addr)) else $error("auto global wrong");
	cover property (ce_i && reg_req_i.rd);
	cover property ($fell(interrupt_pin_low_n_o));
	cover property (socketless_source_select_o == 8'h03);
endmodule // emcs_event_ctrl_asserts
bind emcs_event_ctrl emcs_event_ctrl_asserts chk_u (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .ce_i(ce_i),
	.reg_req_i(reg_req_i), .reg_rdata_o(reg_rdata_o), .per_socket_flags_i(per_socket_flags_i),
	.global_interrupt_enable_i(global_interrupt_enable_i), .interrupt_pin_low_n_o(interrupt_pin_low_n_o),
	.ipv6_addrs_i(ipv6_addrs_i), .socketless_source_select_o(socketless_source_select_o),
	.chosen_source_ipv6_o(chosen_source_ipv6_o));
`default_nettype wire

// ===== testbench.sv
// testbench: self-checking bench for emcs_event_ctrl
// assumes emcs_pkg and the checker are compiled first
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import emcs_pkg::*;
	typedef struct packed {
		logic [1:0] what;
		logic [127:0] val;
	} emcs_note_t;
	// ------------------------------------------------------------
	// signals
	// ------------------------------------------------------------
	localparam logic [15:0] RST_OFS [10] = '{16'h2100, 16'h2101, 16'h2102, 16'h2104, 16'h2108, 16'h2114,
		16'h2124, 16'h2128, 16'h212c, 16'h2105};
	localparam logic [15:0] RW_OFS [4] = '{16'h2104, 16'h2114, 16'h2124, 16'h212c};
	localparam logic [7:0] CODES [4] = '{8'h00, 8'h02, 8'h03, 8'h01};
	logic clk_sys_i = 1'b0;
	logic srst_i = 1'b1;
	logic ce_i = 1'b1;
	emcs_reg_req_t req = '0;
	logic [7:0] cset = 8'h00;
	logic [7:0] slset = 8'h00;
	logic [63:0] psock = 64'h0;
	logic gen = 1'b0;
	emcs_ipv6_set_t addrs = '0;
	emcs_ipv6_set_t a;
	logic look = 1'b0;
	logic [7:0] rdata;
	logic pin_n;
	logic [7:0] sel;
	logic [127:0] chosen;
	logic [127:0] got;
	logic [7:0] lfsr = 8'h52;
	logic [7:0] v;
	logic [7:0] bv;
	logic [15:0] mo;
	emcs_note_t exp_q[$];
	emcs_note_t note;
	int fail_count = 0;
	int total_checks = 0;
	logic rd_taken_r = 1'b0;
	always #4 clk_sys_i = ~clk_sys_i;
	emcs_event_ctrl dut_u (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .ce_i(ce_i), .reg_req_i(req),
		.reg_rdata_o(rdata), .common_event_set_i(cset), .socketless_event_set_i(slset),
		.per_socket_flags_i(psock), .global_interrupt_enable_i(gen), .interrupt_pin_low_n_o(pin_n),
		.ipv6_addrs_i(addrs), .socketless_source_select_o(sel), .chosen_source_ipv6_o(chosen));
	// ------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------
	function automatic logic [7:0] rnd();
		lfsr = {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
		return lfsr;
	endfunction
	task automatic wr(input logic [15:0] ad, input logic [7:0] d);
		@(posedge clk_sys_i);
		req.wr <= 1'b1;
		req.addr <= ad;
		req.wdata <= d;
		@(posedge clk_sys_i);
		req.wr <= 1'b0;
	endtask
	task automatic rd(input logic [15:0] ad, input logic [7:0] e);
		@(posedge clk_sys_i);
		req.rd <= 1'b1;
		req.addr <= ad;
		exp_q.push_back({2'd0, 120'h0, e});
		@(posedge clk_sys_i);
		req.rd <= 1'b0;
	endtask
	// pin and chosen address are levels, so one look a cycle suffices
	task automatic look_at(input logic [1:0] w, input logic [127:0] e);
		exp_q.push_back({w, e});
		@(posedge clk_sys_i);
		look <= 1'b1;
		@(posedge clk_sys_i);
		look <= 1'b0;
	endtask
	task automatic pulse(input int k, input logic [7:0] m);
		@(posedge clk_sys_i);
		if (k == 1) slset <= m;
		else cset <= m;
		@(posedge clk_sys_i);
		cset <= 8'h00;
		slset <= 8'h00;
	endtask
	task automatic print_verdict();
		if (fail_count == 0 && total_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	// ------------------------------------------------------------
	// monitor
	// ------------------------------------------------------------
	// read data is registered: look at the falling edge after the edge that took the read
	always @(posedge clk_sys_i) begin
		rd_taken_r <= req.rd && ce_i;
	end
	always @(negedge clk_sys_i) begin
		if ((rd_taken_r || look) && exp_q.size() > 0) begin
			note = exp_q.pop_front();
			got = (note.what == 2'd0) ? {120'h0, rdata} : (note.what == 2'd1) ? {127'h0, pin_n} :
				(note.what == 2'd2) ? chosen : {120'h0, sel};
			total_checks++;
			if (got !== note.val) begin
				fail_count++;
				$display("wrong value at %0t: kind %0d got %h want %h", $time, note.what, got, note.val);
			end
		end
	end
	initial begin
		#(8 * 20000);
		fail_count++;
		print_verdict();
	end
	// ------------------------------------------------------------
	// sequence
	// ------------------------------------------------------------
	initial begin
		repeat (8) @(posedge clk_sys_i);
		srst_i <= 1'b0;
		gen <= 1'b1;
		foreach (RST_OFS[i]) rd(RST_OFS[i], 8'h00);
		look_at(2'd1, 128'h1);
		foreach (RW_OFS[i]) begin
			v = rnd();
			wr(RW_OFS[i], v);
			rd(RW_OFS[i], (i == 0) ? (v & EMCS_COMMON_VALID) : v);
		end
		wr(16'h2108, 8'hff);
		rd(16'h2108, 8'h00);
		wr(16'h2100, 8'hff);
		rd(16'h2100, 8'h00);
		wr(16'h2114, 8'h3c);
		ce_i <= 1'b0;
		wr(16'h2114, 8'hc3);
		ce_i <= 1'b1;
		rd(16'h2114, 8'h3c);
		wr(16'h2114, 8'h00);
		for (int k = 0; k < 2; k++) begin
			mo = k ? 16'h2124 : 16'h2104;
			for (int b = 0; b < 8; b++) begin
				bv = 8'h01 << b;
				v = (k == 1 || EMCS_COMMON_VALID[b]) ? bv : 8'h00;
				wr(mo, ~bv);
				pulse(k, bv);
				look_at(2'd1, 128'h1);
				wr(mo, bv);
				look_at(2'd1, {127'h0, v == 8'h00});
				gen <= 1'b0;
				look_at(2'd1, 128'h1);
				gen <= 1'b1;
				wr(mo + 16'h0004, ~bv);
				rd(k ? 16'h2102 : 16'h2100, v);
				wr(mo + 16'h0004, bv);
				rd(k ? 16'h2102 : 16'h2100, 8'h00);
				look_at(2'd1, 128'h1);
			end
			wr(mo, 8'h00);
		end
		for (int n = 0; n < 8; n++) begin
			v = rnd() | 8'h01;
			psock <= 64'(v) << (8 * n);
			wr(16'h2114, ~(8'h01 << n));
			look_at(2'd1, 128'h1);
			rd(16'h2101, 8'h01 << n);
			wr(16'h2114, 8'h01 << n);
			look_at(2'd1, 128'h0);
		end
		psock <= 64'h0;
		foreach (CODES[c]) begin
			wr(16'h212c, CODES[c]);
			rd(16'h212c, CODES[c]);
			look_at(2'd3, {120'h0, CODES[c]});
			for (int j = 0; j < 3; j++) begin
				a.link_local = {16{rnd()}};
				a.global_addr = {16{rnd()}};
				a.dest = {16{rnd()}};
				if (j == 0) a.dest[127:118] = 10'h3fa;
				else if (j == 1) a.dest[127:125] = 3'h1;
				else a.dest[127:120] = 8'hff;
				addrs <= a;
				look_at(2'd2, (c == 1 || (c != 2 && j == 0)) ? a.link_local : a.global_addr);
			end
		end
		wr(16'h2104, 8'h97);
		srst_i <= 1'b1;
		repeat (2) @(posedge clk_sys_i);
		srst_i <= 1'b0;
		rd(16'h2104, 8'h00);
		look_at(2'd1, 128'h1);
		repeat (2) @(posedge clk_sys_i);
		print_verdict();
	end
endmodule // testbench
`default_nettype wire
